// ==== common/pin_control_pkg.sv ====
// Purpose: Types of the channel pin control block
// Assumes: Nothing beyond the register header
// Notes:   Modes, clock choices and packed carriers
package pin_control_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SYNC_ASYNC, SYNC_EXTERNAL, SYNC_INTERNAL, SYNC_SDLC} sync_mode_e;
  typedef enum logic [1:0] {CODE_NRZ, CODE_NRZI, CODE_FM, CODE_FM2} line_code_e;
  typedef enum logic [1:0] {RATE_X1, RATE_X16, RATE_X32, RATE_X64} rate_e;
  typedef enum logic [1:0] {REQ_WAIT, REQ_TX, REQ_RX, REQ_OFF} req_fn_e;
  typedef enum logic [2:0] {TOUT_PLL, TOUT_XTAL, TOUT_BRG, TOUT_TXCLK, TOUT_IN} tx_rx_clock_pin_src_e;

  // ----------------------------------------------------------------
  // Mode register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    tx_rx_clock_pin_src_e  tx_rx_clock_pin_src;
    logic       xtal_en;
    logic [1:0] rx_src;
    logic [1:0] tx_src;
    req_fn_e    req_fn;
    rate_e      rate;
    line_code_e code;
    sync_mode_e sync_mode;
  } mode_s;

  // ----------------------------------------------------------------
  // Engine-side signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_empty;
    logic tx_dma_req;
    logic rx_dma_req;
    logic cpu_wait;
    logic sync_match;
    logic flag_seen;
    logic pll_clk;
    logic brg_clk;
    logic xtal_clk;
    logic tx_clk_int;
  } engine_s;

endpackage

// ==== common/pin_control_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the channel pin control block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Included by the design and by the bench
`ifndef PIN_CONTROL_REGS_SVH
`define PIN_CONTROL_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_RX_CTRL    8'h00
`define OFS_TX_CTRL    8'h04
`define OFS_MISC_CTRL  8'h08
`define OFS_MODE_CTRL  8'h0C
`define OFS_STATUS     8'h10
`define OFS_CHANGE     8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_AUTO_EN    5
`define BIT_DMA_SEL    2
`define BIT_RTS        1
`define BIT_DTR        7
`define BIT_TX_RX_CLOCK_PIN_OUT   2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RX_CTRL    8'h00
`define RST_TX_CTRL    8'h00
`define RST_MISC_CTRL  8'h00
`define RST_MODE_CTRL  16'h0000

`endif

// ==== src/serial_channel_pin_control.sv ====
// Purpose: Modem, sync, request and clock pin logic of one serial channel
// Assumes: Pins are asynchronous to aclk; engine signals are on aclk
// Notes:   Outputs named _n are active low
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pin_control_regs.svh"

module serial_channel_pin_control
  import pin_control_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cts_n,
  input  wire logic        dcd_n,
  input  wire logic        rx_tx_clock_pin,
  input  wire logic        rxd,
  input  wire logic        sync_in_n,
  output      logic        sync_out_n,
  output      logic        sync_oe,
  input  wire logic        tx_rx_clock_in,
  output      logic        tx_rx_clock_pin,
  output      logic        tx_rx_clock_oe,
  output      logic        rts_n,
  output      logic        dtr_req_n,
  output      logic        wait_req_n,
  output      logic        wait_req_oe,
  input  wire engine_s     engine,
  output      logic        tx_enable,
  output      logic        rx_enable,
  output      logic        rx_sample,
  output      logic        rx_data_q,
  output      logic        tx_shift,
  output      logic        char_start,
  output      logic        ext_status_event
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] edges(input logic cur, input logic prev);
    edges = {cur & ~prev, ~cur & prev};
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  receive_control_register_q;
  logic [7:0]  transmit_control_register_q;
  logic [7:0]  misc_clock_control_register_q;
  logic [15:0] mode_q;
  logic [3:0]  change_q;
  mode_s       mode;
  logic        auto_en;
  logic        async_mode;

  assign mode       = mode_s'(mode_q);
  assign auto_en    = receive_control_register_q[`BIT_AUTO_EN];
  assign async_mode = (mode.sync_mode == SYNC_ASYNC);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] prev_q;
  logic [4:0] pins;

  assign pins = {tx_rx_clock_in, rxd, sync_in_n, dcd_n, cts_n};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 5'h1F;
      sync_q <= 5'h1F;
      prev_q <= 5'h1F;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic rx_tx_clock_pin_meta_q;
  logic rx_tx_clock_pin_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_tx_clock_pin_meta_q <= 1'b1;
      rx_tx_clock_pin_q      <= 1'b1;
    end else begin
      rx_tx_clock_pin_meta_q <= rx_tx_clock_pin;
      rx_tx_clock_pin_q      <= rx_tx_clock_pin_meta_q;
    end
  end

  logic [1:0] cts_edge;
  logic [1:0] dcd_edge;
  logic [1:0] syn_edge;

  assign cts_edge = edges(sync_q[0], prev_q[0]);
  assign dcd_edge = edges(sync_q[1], prev_q[1]);
  assign syn_edge = edges(sync_q[2], prev_q[2]);

  // ----------------------------------------------------------------
  // Modem enables
  // ----------------------------------------------------------------
  assign tx_enable = auto_en ? ~sync_q[0] : 1'b1;
  assign rx_enable = auto_en ? ~sync_q[1] : 1'b1;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  logic       sync_in_used;
  logic       change_clr;
  logic [3:0] change_clr_mask;

  assign sync_in_used = (mode.sync_mode == SYNC_ASYNC || mode.sync_mode == SYNC_EXTERNAL) && !mode.xtal_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_q <= 4'h0;
    end else begin
      change_q <= (change_q & ~(change_clr ? change_clr_mask : 4'h0))
                | {1'b0, sync_in_used & |syn_edge, |dcd_edge, |cts_edge};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_status_event <= 1'b0;
    end else begin
      ext_status_event <= (|cts_edge | |dcd_edge | (sync_in_used & |syn_edge)) & ~|change_q;
    end
  end

  // ----------------------------------------------------------------
  // Request to send
  // ----------------------------------------------------------------
  logic rts_hold_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_hold_q <= 1'b0;
    end else if (transmit_control_register_q[`BIT_RTS]) begin
      rts_hold_q <= 1'b1;
    end else if (!(async_mode && auto_en) || engine.tx_empty) begin
      rts_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n <= 1'b1;
    end else if (async_mode && auto_en) begin
      rts_n <= ~(transmit_control_register_q[`BIT_RTS] | rts_hold_q);
    end else begin
      rts_n <= ~transmit_control_register_q[`BIT_RTS];
    end
  end

  // ----------------------------------------------------------------
  // Terminal ready and wait/request
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr_req_n <= 1'b1;
    end else if (misc_clock_control_register_q[`BIT_DMA_SEL]) begin
      dtr_req_n <= ~engine.tx_dma_req;
    end else begin
      dtr_req_n <= ~transmit_control_register_q[`BIT_DTR];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_req_n  <= 1'b1;
      wait_req_oe <= 1'b0;
    end else begin
      case (mode.req_fn)
        REQ_WAIT: begin
          wait_req_n  <= 1'b0;
          wait_req_oe <= engine.cpu_wait;
        end
        REQ_TX: begin
          wait_req_n  <= ~engine.tx_dma_req;
          wait_req_oe <= 1'b1;
        end
        REQ_RX: begin
          wait_req_n  <= ~engine.rx_dma_req;
          wait_req_oe <= 1'b1;
        end
        default: begin
          wait_req_n  <= 1'b1;
          wait_req_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock pins
  // ----------------------------------------------------------------
  logic rclk;
  logic tclk;
  logic rclk_prev_q;
  logic tclk_prev_q;
  logic fm;

  assign fm = mode.code[1];

  always_comb begin
    case (mode.rx_src)
      2'h0:    rclk = rx_tx_clock_pin_q;
      2'h1:    rclk = sync_q[4];
      2'h2:    rclk = engine.brg_clk;
      default: rclk = engine.pll_clk;
    endcase
    case (mode.tx_src)
      2'h0:    tclk = rx_tx_clock_pin_q;
      2'h1:    tclk = sync_q[4];
      2'h2:    tclk = engine.brg_clk;
      default: tclk = engine.pll_clk;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk_prev_q <= 1'b1;
      tclk_prev_q <= 1'b1;
    end else begin
      rclk_prev_q <= rclk;
      tclk_prev_q <= tclk;
    end
  end

  logic [1:0] rclk_edge;
  logic [1:0] tclk_edge;
  logic [5:0] div_q;
  logic [5:0] div_max;

  assign rclk_edge = edges(rclk, rclk_prev_q);
  assign tclk_edge = edges(tclk, tclk_prev_q);

  always_comb begin
    case (mode.rate)
      RATE_X16: div_max = 6'h0F;
      RATE_X32: div_max = 6'h1F;
      RATE_X64: div_max = 6'h3F;
      default:  div_max = 6'h00;
    endcase
    if (!async_mode) begin
      div_max = 6'h00;
    end
  end

  logic rx_tick;

  assign rx_tick = fm ? |rclk_edge : rclk_edge[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 6'h00;
    end else if (rx_tick) begin
      div_q <= (div_q >= div_max) ? 6'h00 : div_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sample <= 1'b0;
      rx_data_q <= 1'b0;
      tx_shift  <= 1'b0;
    end else begin
      rx_sample <= rx_tick && (div_q == (div_max >> 1));
      if (rx_tick && (div_q == (div_max >> 1))) begin
        rx_data_q <= sync_q[3];
      end
      tx_shift  <= fm ? |tclk_edge : tclk_edge[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_rx_clock_pin <= 1'b1;
      tx_rx_clock_oe  <= 1'b0;
    end else begin
      tx_rx_clock_oe <= misc_clock_control_register_q[`BIT_TX_RX_CLOCK_PIN_OUT];
      case (mode.tx_rx_clock_pin_src)
        TOUT_PLL:   tx_rx_clock_pin <= engine.pll_clk;
        TOUT_XTAL:  tx_rx_clock_pin <= engine.xtal_clk;
        TOUT_BRG:   tx_rx_clock_pin <= engine.brg_clk;
        TOUT_TXCLK: tx_rx_clock_pin <= engine.tx_clk_int;
        default:    tx_rx_clock_pin <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sync pin
  // ----------------------------------------------------------------
  logic ext_armed_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_armed_q <= 1'b0;
      char_start  <= 1'b0;
    end else begin
      char_start <= 1'b0;
      if (mode.sync_mode == SYNC_EXTERNAL && !mode.xtal_en) begin
        if (syn_edge[0]) begin
          ext_armed_q <= 1'b1;
        end else if (ext_armed_q && rclk_edge[1]) begin
          ext_armed_q <= 1'b0;
          char_start  <= 1'b1;
        end
      end else begin
        ext_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out_n <= 1'b1;
      sync_oe    <= 1'b0;
    end else if (mode.sync_mode == SYNC_INTERNAL && !mode.xtal_en) begin
      sync_out_n <= ~engine.sync_match;
      sync_oe    <= 1'b1;
    end else if (mode.sync_mode == SYNC_SDLC) begin
      sync_out_n <= ~engine.flag_seen;
      sync_oe    <= 1'b1;
    end else begin
      sync_out_n <= 1'b1;
      sync_oe    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       do_write;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
  assign change_clr    = do_write && aw_addr_q == `OFS_CHANGE && w_strb_q[0];
  assign change_clr_mask = w_data_q[3:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == `OFS_RX_CTRL || aw_addr_q == `OFS_TX_CTRL || aw_addr_q == `OFS_MISC_CTRL
            || aw_addr_q == `OFS_MODE_CTRL || aw_addr_q == `OFS_CHANGE || aw_addr_q == `OFS_STATUS) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_control_register_q    <= `RST_RX_CTRL;
      transmit_control_register_q   <= `RST_TX_CTRL;
      misc_clock_control_register_q <= `RST_MISC_CTRL;
      mode_q                        <= `RST_MODE_CTRL;
    end else if (do_write) begin
      if (aw_addr_q == `OFS_RX_CTRL && w_strb_q[0]) begin
        receive_control_register_q <= w_data_q[7:0];
      end else if (aw_addr_q == `OFS_TX_CTRL && w_strb_q[0]) begin
        transmit_control_register_q <= w_data_q[7:0];
      end else if (aw_addr_q == `OFS_MISC_CTRL && w_strb_q[0]) begin
        misc_clock_control_register_q <= w_data_q[7:0];
      end else if (aw_addr_q == `OFS_MODE_CTRL) begin
        if (w_strb_q[0]) begin
          mode_q[7:0] <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          mode_q[15:8] <= w_data_q[15:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      if (s_axi_araddr == `OFS_RX_CTRL) begin
        s_axi_rdata <= {24'h000000, receive_control_register_q};
      end else if (s_axi_araddr == `OFS_TX_CTRL) begin
        s_axi_rdata <= {24'h000000, transmit_control_register_q};
      end else if (s_axi_araddr == `OFS_MISC_CTRL) begin
        s_axi_rdata <= {24'h000000, misc_clock_control_register_q};
      end else if (s_axi_araddr == `OFS_MODE_CTRL) begin
        s_axi_rdata <= {16'h0000, mode_q};
      end else if (s_axi_araddr == `OFS_STATUS) begin
        // buffer_external_status_register: status_bit_a is bit 4
        s_axi_rdata <= {24'h000000, ~sync_q[0], 2'h0, ~sync_q[2], ~sync_q[1], engine.tx_empty, 2'h0};
      end else if (s_axi_araddr == `OFS_CHANGE) begin
        s_axi_rdata <= {28'h0000000, change_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // serial_channel_pin_control

// ==== testbench/line_partner.sv ====
// Purpose: Modem and line side of one channel
// Assumes: Pin clock period of eight aclk cycles
// Notes:   Clock stands still and data toggles outside frames
`timescale 1ns/100ps
module line_partner (
  input  wire logic aclk,
  input  wire logic frame,
  input  wire logic hunt,
  input  wire logic idle_lvl,
  output logic      line_clk,
  output logic      rxd,
  output logic      sync_n
);
  logic [1:0] div_q = 2'h0;
  logic [1:0] edg_q = 2'h0;
  initial begin
    line_clk = 1'h1;
    rxd = 1'h0;
    sync_n = 1'h1;
  end
  always @(posedge aclk) begin
    div_q <= frame ? div_q + 2'h1 : 2'h0;
    if (frame && div_q == 2'h3)
      line_clk <= ~line_clk;
    if (frame && div_q == 2'h3 && !line_clk && edg_q != 2'h2)
      edg_q <= edg_q + 2'h1;
    if (!hunt)
      edg_q <= 2'h0;
    rxd <= frame ? 1'($urandom) : ~rxd;
    sync_n <= hunt ? edg_q != 2'h2 : idle_lvl;
  end
endmodule // line_partner

// ==== testbench/pin_control_props.sv ====
// Purpose: Assertions on the channel pin outputs
// Assumes: Bench drives engine sync_match and flag_seen alike
// Notes:   Bound to the design below
`timescale 1ns/100ps
module pin_control_props
  import pin_control_pkg::*;
(
  input wire logic    aclk,
  input wire logic    aresetn,
  input wire logic    cts_n,
  input wire logic    dcd_n,
  input wire logic    sync_in_n,
  input wire logic    rxd,
  input wire logic    rx_sample,
  input wire logic    rx_data_q,
  input wire logic    sync_out_n,
  input wire logic    sync_oe,
  input wire logic    tx_rx_clock_pin,
  input wire logic    tx_rx_clock_oe,
  input wire logic    dtr_req_n,
  input wire logic    wait_req_n,
  input wire logic    wait_req_oe,
  input wire engine_s engine,
  input wire logic    tx_enable,
  input wire logic    rx_enable,
  input wire logic    char_start,
  input wire logic    ext_status_event
);
  logic [14:0] hist_q;
  always_ff @(posedge aclk) hist_q <= {hist_q[11:0], cts_n, dcd_n, sync_in_n};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_gate; !tx_enable |-> $past(cts_n, 2); endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx enable wrong");
  property p_rx_gate; !rx_enable |-> $past(dcd_n, 2); endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx enable wrong");
  property p_evt_pulse; ext_status_event |=> !ext_status_event; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event too long");
  property p_evt_cause; ext_status_event |-> hist_q[14:3] != hist_q[11:0]; endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without edge");
  property p_dma; tx_rx_clock_oe && $past(tx_rx_clock_oe) |-> dtr_req_n == !$past(engine.tx_dma_req); endproperty
  a_dma: assert property (p_dma) else $error("dma request wrong");
  property p_clk_out; tx_rx_clock_oe && $past(tx_rx_clock_oe) |-> tx_rx_clock_pin == $past(engine.pll_clk); endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out wrong");
  property p_sync_out; sync_oe && $past(sync_oe) |-> sync_out_n == !$past(engine.sync_match); endproperty
  a_sync_out: assert property (p_sync_out) else $error("sync out wrong");
  property p_start; char_start |=> !char_start; endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_wait; !wait_req_oe && $past(aresetn) |-> !wait_req_n; endproperty
  a_wait: assert property (p_wait) else $error("wait level wrong");
  property p_rx_data; rx_sample |-> rx_data_q == $past(rxd, 3); endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx data wrong");
endmodule // pin_control_props

bind serial_channel_pin_control pin_control_props u_props (.*);

// ==== testbench/test_serial_channel_pin_control.sv ====
// Purpose: Self-checking bench of the channel pin block
// Assumes: Offsets and bits from the register header
// Notes:   Seeded random engine and modem levels
`timescale 1ns/100ps
`include "pin_control_regs.svh"
`define CHK(w, e, s) chk(w, e, s)
module test_serial_channel_pin_control
  import pin_control_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, cts_n = 1'h1, dcd_n = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q, rv, ns, nt;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, frame = 1'h0, hunt = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, pv;
  logic        rx_tx_clock_pin, rxd, sync_in_n, sync_out_n, sync_oe, tx_rx_clock_pin;
  logic        tx_rx_clock_oe, rts_n, dtr_req_n, wait_req_n, wait_req_oe, tx_enable, rx_enable;
  logic        rx_sample, rx_data_q, tx_shift, char_start, ext_status_event;
  logic        idle_lvl = 1'h1;
  engine_s     engine = '0;
  wire         tx_rx_clock_in = rx_tx_clock_pin;
  int          n_mismatch = 0, cmp_count = 0, n_evt = 0;

  serial_channel_pin_control DUT (.*);
  line_partner partner (.aclk(aclk), .frame(frame), .hunt(hunt), .idle_lvl(idle_lvl),
    .line_clk(rx_tx_clock_pin), .rxd(rxd), .sync_n(sync_in_n));

  always #2 aclk = ~aclk;
  always @(negedge aclk) n_evt += ext_status_event;

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, done;
    @(posedge aclk);
    done = 1'h0;
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    while (!done) begin
      @(negedge aclk);
      ka = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      kw = s_axi_wvalid & s_axi_wready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'h0;
      if (ka) s_axi_arvalid <= 1'h0;
      if (kw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    xfer(1'h0, a, 32'h0);
    `CHK("read data", e, q & m);
    `CHK("read resp", er, r);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end

  initial begin
    rv = $urandom(205);
    pv = 2'h3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0, 32'hFFFF, 2'h0);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, 2'h2);
    `CHK("wait level", 1'h0, wait_req_n);
    `CHK("wait drive", 1'h0, wait_req_oe);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_MODE_CTRL, m);
      wr(`OFS_RX_CTRL, 32'h1 << `BIT_AUTO_EN);
      wr(`OFS_TX_CTRL, 32'h1 << `BIT_RTS);
      settle(2);
      `CHK("rts set", 1'h0, rts_n);
      `CHK("sync drive", m >= 2, sync_oe);
      wr(`OFS_TX_CTRL, 32'h0);
      settle(4);
      `CHK("rts clear", m == 0 ? 1'h0 : 1'h1, rts_n);
      @(posedge aclk);
      engine.tx_empty <= 1'h1;
      settle(4);
      `CHK("rts empty", 1'h1, rts_n);
      @(posedge aclk);
      engine.tx_empty <= 1'h0;
    end
    wr(`OFS_MODE_CTRL, 32'h0);
    wr(`OFS_RX_CTRL, 32'h0);
    wr(`OFS_TX_CTRL, 32'h1 << `BIT_RTS);
    wr(`OFS_TX_CTRL, 32'h1 << `BIT_DTR);
    settle(3);
    `CHK("rts follow", 1'h1, rts_n);
    `CHK("dtr level", 1'h0, dtr_req_n);
    wr(`OFS_MISC_CTRL, 32'h1 << `BIT_DMA_SEL);
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      engine.tx_dma_req <= v[0];
      engine.pll_clk <= v[0];
      settle(2);
      `CHK("dma request", !v[0], dtr_req_n);
      `CHK("clock out", {1'h1, v[0]}, {tx_rx_clock_oe, tx_rx_clock_pin});
    end
    wr(`OFS_RX_CTRL, 32'h1 << `BIT_AUTO_EN);
    wr(`OFS_CHANGE, 32'h7);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      {dcd_n, cts_n} <= ~i[1:0];
      settle(5);
      `CHK("tx gate", !cts_n, tx_enable);
      `CHK("rx gate", !dcd_n, rx_enable);
      rd(`OFS_CHANGE, 32'({dcd_n, cts_n} ^ pv), 32'h3, 2'h0);
      rd(`OFS_STATUS, 32'({!cts_n, 3'h0, !dcd_n, 3'h0}), 32'h88, 2'h0);
      wr(`OFS_CHANGE, 32'h3);
      pv = {dcd_n, cts_n};
    end
    `CHK("status events", 32'h3, n_evt);
    wr(`OFS_RX_CTRL, 32'h0);
    cts_n <= 1'h1;
    dcd_n <= 1'h1;
    settle(5);
    `CHK("enables free", 2'h3, {tx_enable, rx_enable});
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      idle_lvl <= v[0];
      settle(5);
      rd(`OFS_STATUS, 32'(!v[0]) << 4, 32'h10, 2'h0);
    end
    for (int f = 0; f < 3; f++) begin
      wr(`OFS_MODE_CTRL, f << 6);
      for (int v = 0; v < 2; v++) begin
        @(posedge aclk);
        {engine.tx_dma_req, engine.rx_dma_req, engine.cpu_wait} <= {3{v[0]}};
        settle(2);
        `CHK("req drive", f == 0 ? v[0] : 1'h1, wait_req_oe);
        `CHK("req level", f == 0 ? 1'h0 : !v[0], wait_req_n);
      end
    end
    frame <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      wr(`OFS_MODE_CTRL, (k < 3 ? k << 2 : (k - 2) << 4) + (k == 1 ? 32'h500 : 32'h0));
      settle(600);
      ns = 32'h0;
      nt = 32'h0;
      repeat (512) begin
        @(negedge aclk);
        ns = ns + rx_sample;
        nt = nt + tx_shift;
      end
      `CHK("rx samples", (k == 2 ? 128 : 64) >> (k < 3 ? 0 : k + 1), ns);
      if (k < 3) `CHK("tx shifts", k == 2 ? 128 : 64, nt);
    end
    wr(`OFS_MODE_CTRL, 32'h1);
    hunt <= 1'h1;
    ns = 32'h0;
    repeat (200) @(negedge aclk) ns = ns + char_start;
    `CHK("char start", 32'h1, ns);
    for (int m = 2; m < 4; m++) begin
      wr(`OFS_MODE_CTRL, m);
      hunt <= 1'h0;
      repeat (300) begin
        rv = $urandom;
        engine <= {engine.tx_empty, rv[7:5], rv[4], rv[4], rv[3:0]};
        if (rv[12:9] == 4'h0) cts_n <= ~cts_n;
        if (rv[16:13] == 4'h0) dcd_n <= ~dcd_n;
        @(posedge aclk);
      end
    end
    final_report;
  end
endmodule // test_serial_channel_pin_control
